// file: design/lmcp_consts.svh
/*
 Byte offsets, field positions and fixed codes of the capability region.
 Assumes inclusion by the capability package; the capability module uses its macros without including it.
*/
`ifndef LMCP_CONSTS_SVH
`define LMCP_CONSTS_SVH

`define LMCP_OFS_PAGES        8'h8e
`define LMCP_OFS_DURATIONS    8'h8f
`define LMCP_OFS_DUR_RSVD     8'h90
`define LMCP_OFS_CHARACTER    8'h91
`define LMCP_OFS_TEMP_MAX     8'h92
`define LMCP_OFS_TEMP_MIN     8'h93
`define LMCP_OFS_CHR_RSVD_A   8'h94
`define LMCP_OFS_VOLT_FLOOR   8'h96
`define LMCP_OFS_DISABLE      8'h97
`define LMCP_OFS_CHR_RSVD_B   8'h98
`define LMCP_OFS_CONTROLS_A   8'h9b
`define LMCP_OFS_CONTROLS_B   8'h9c
`define LMCP_OFS_FLAGS        8'h9d
`define LMCP_OFS_FLAGS_RSVD   8'h9e
`define LMCP_OFS_MONITORS_A   8'h9f
`define LMCP_OFS_MONITORS_B   8'ha0
`define LMCP_OFS_CMD_BLOCK    8'ha3

`define LMCP_POS_WAIT_EXP     5
`define LMCP_POS_BIAS_MULT    3
`define LMCP_POS_INSTANCES    6

`define LMCP_BANK_RSVD        2'h3
`define LMCP_BIAS_RSVD        2'h3
`define LMCP_INST_RSVD        2'h3
`define LMCP_STATE_DUR_MAX    4'hd
`define LMCP_EPL_CODE_MAX     4'h7

`define LMCP_EPL_FIRST_PAGE   8'ha0
`define LMCP_PAGE_ADDR_FIRST  8'h80
`define LMCP_PAGE_ADDR_LAST   8'hff

`endif

// file: design/lmcp_pkg.sv
/*
 Types shared by the capability region.
 Assumes the constants header is on the include path.
*/
`default_nettype none

package lmcp_pkg;
  `include "lmcp_consts.svh"

  typedef logic [7:0] lmcp_byte_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    lmcp_byte_t addr;
    lmcp_byte_t wdata;
  } lmcp_req_s;

  typedef struct packed {
    logic       valid;
    lmcp_byte_t rdata;
  } lmcp_rsp_s;

  typedef struct packed {
    logic       advance;
    lmcp_byte_t page;
    lmcp_byte_t addr;
  } lmcp_ptr_s;
endpackage

`default_nettype wire

// file: design/lmcp_capability_page.sv
/*
 Read-only capability region, bytes 0x8e..0xa3 of the advertising page,
 plus the address pointer advance and laser lane shutoff combining.
 Assumes a serial bus engine on CLK that hands over byte requests, and a
 select pin from the host that is asynchronous to CLK.
*/
// Behaviour
// [R1] Lane bank range two-bit code, 11b reserved
// [R2] Settle wait is mantissa times two-power exponent
// [R3] All-zero durations byte means wait unknown
// [R4] Host waits settle time around each transaction
// [R5] State duration four-bit code, 1110b/1111b reserved
// [R6] Top characteristics bit marks cooled transmitter
// [R7] Three bits pick aux monitor sources
// [R8] Signed case temperature limits, zero both unspecified
// [R9] Supply floor in 20 mV steps, zero unspecified
// [R10] Global shutoff: any lane off disables all
// [R11] Fast shutoff bit only for fast timing
// [R12] Lane-off capable bit reports disable register
// [R13] Bit 6 tunable, bit 7 wavelength control
// [R14] Top bit reports bank broadcast capability
// [R15] Flag support bits: loss bit 1, fault 0
// [R16] Monitor presence bits in first monitors byte
// [R17] Bias step multiplier bits 4-3, monitors bits 1-0
// [R18] Command block instance count in bits 7-6
// [R19] Background bit allows access during commands
// [R20] Auto paging advances page, wraps to A0h
// [R21] Payload page range code in bits 3-0
// [R22] All fields static and read-only
// [R23] Reserved bits and bytes read zero
`default_nettype none

module lmcp_capability_page
  import lmcp_pkg::*;
#(
  parameter int         LANES            = 8,
  parameter logic [1:0] LANE_BANK_RANGE  = 2'h0,
  parameter logic       VENDOR_PAGES     = 1'b0,
  parameter logic       DIAG_PAGE        = 1'b0,
  parameter logic       PAGE_06_PRESENT  = 1'b0,
  parameter logic       PAGE_05_PRESENT  = 1'b0,
  parameter logic       PAGE_03_PRESENT  = 1'b0,
  parameter logic       WAIT_KNOWN       = 1'b1,
  parameter logic [2:0] WAIT_EXPONENT    = 3'h6,
  parameter logic [4:0] WAIT_MANTISSA    = 5'h19,
  parameter logic [3:0] STATE_DUR_CODE   = 4'h0,
  parameter logic       COOLED           = 1'b0,
  parameter logic [2:0] AUX_SOURCE       = 3'h0,
  parameter logic [7:0] TEMP_MAX         = 8'h00,
  parameter logic [7:0] TEMP_MIN         = 8'h00,
  parameter logic [7:0] VOLT_FLOOR       = 8'h00,
  parameter logic       FAST_SHUTOFF     = 1'b0,
  parameter logic       GLOBAL_SHUTOFF   = 1'b0,
  parameter logic       WAVE_CONTROL     = 1'b0,
  parameter logic       TUNABLE          = 1'b0,
  parameter logic       LANE_OFF_CAPABLE = 1'b1,
  parameter logic       BROADCAST        = 1'b0,
  parameter logic       LOSS_FLAG        = 1'b0,
  parameter logic       FAULT_FLAG       = 1'b0,
  parameter logic [5:0] MONITORS         = 6'h00,
  parameter logic [1:0] BIAS_MULT        = 2'h0,
  parameter logic       OPT_POWER_MON    = 1'b0,
  parameter logic       BIAS_MON         = 1'b0,
  parameter logic [1:0] CMD_INSTANCES    = 2'h0,
  parameter logic       BACKGROUND       = 1'b0,
  parameter logic       AUTO_PAGE        = 1'b0,
  parameter logic [3:0] EPL_RANGE        = 4'h0
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_B,
  // Host select pin
  input  wire logic             MODULE_SELECT_LINE_N,
  // Byte access from the serial engine
  input  wire lmcp_req_s        REQ,
  output lmcp_rsp_s             RSP,
  // Address pointer advance
  input  wire lmcp_ptr_s        PTR_IN,
  output lmcp_ptr_s             PTR_OUT,
  // Laser lane shutoff
  input  wire logic [LANES-1:0] LASER_LANE_OFF,
  output logic [LANES-1:0]      LASER_LANE_DISABLE,
  // Static duration code
  output logic [3:0]            STATE_DURATION_CODE
);

  // Parameter checks
  if (LANES < 1) begin : g_bad_lanes
    $error("LANES must be at least one");
  end
  if (LANE_BANK_RANGE == `LMCP_BANK_RSVD) begin : g_bad_bank // [R1]
    $error("Lane bank range code is reserved");
  end
  if (STATE_DUR_CODE > `LMCP_STATE_DUR_MAX) begin : g_bad_dur // [R5]
    $error("State duration code is reserved");
  end
  if (BIAS_MULT == `LMCP_BIAS_RSVD) begin : g_bad_bias // [R17]
    $error("Bias step multiplier code is reserved");
  end
  if (CMD_INSTANCES == `LMCP_INST_RSVD) begin : g_bad_inst // [R18]
    $error("Command block instance code is reserved");
  end
  if (EPL_RANGE > `LMCP_EPL_CODE_MAX) begin : g_bad_epl // [R21]
    $error("Payload page range code is reserved");
  end

  // Capability bytes, fixed at elaboration
  localparam lmcp_byte_t PAGES_BYTE = {1'b0, VENDOR_PAGES, DIAG_PAGE,
    PAGE_06_PRESENT, PAGE_05_PRESENT, PAGE_03_PRESENT,
    LANE_BANK_RANGE}; // [R1] [R23]
  localparam lmcp_byte_t DUR_BYTE = WAIT_KNOWN ?
    {WAIT_EXPONENT, WAIT_MANTISSA} : 8'h00; // [R2] [R3]
  localparam lmcp_byte_t CHAR_BYTE = {COOLED, 4'h0, AUX_SOURCE}; // [R6] [R7]
  localparam lmcp_byte_t DIS_BYTE = {6'h00, FAST_SHUTOFF,
    GLOBAL_SHUTOFF}; // [R11] [R23]
  localparam lmcp_byte_t CTRL_A_BYTE = {WAVE_CONTROL, TUNABLE, 4'h0,
    LANE_OFF_CAPABLE, 1'b0}; // [R12] [R13]
  localparam lmcp_byte_t CTRL_B_BYTE = {BROADCAST, 7'h00}; // [R14]
  localparam lmcp_byte_t FLAG_BYTE = {6'h00, LOSS_FLAG, FAULT_FLAG}; // [R15]
  localparam lmcp_byte_t MON_A_BYTE = {2'h0, MONITORS}; // [R16]
  localparam lmcp_byte_t MON_B_BYTE = {3'h0, BIAS_MULT, 1'b0,
    OPT_POWER_MON, BIAS_MON}; // [R17]
  localparam lmcp_byte_t CMD_BYTE = {CMD_INSTANCES, BACKGROUND, AUTO_PAGE,
    EPL_RANGE}; // [R18] [R19] [R21]

  // Last payload page from the range code
  localparam lmcp_byte_t EPL_COUNT =
    (EPL_RANGE == 4'h5) ? 8'h08 :
    (EPL_RANGE == 4'h6) ? 8'h0c :
    (EPL_RANGE == 4'h7) ? 8'h10 : {4'h0, EPL_RANGE}; // [R21]
  localparam lmcp_byte_t EPL_LAST = 8'(`LMCP_EPL_FIRST_PAGE + EPL_COUNT - 1);
  localparam logic AUTO_ON = AUTO_PAGE && (EPL_RANGE != 4'h0);

  // Select pin synchroniser
  logic sel_meta_ff;
  logic sel_sync_ff;
  logic nxt_sel_meta;
  logic nxt_sel_sync;

  always_comb begin
    nxt_sel_meta = ~MODULE_SELECT_LINE_N;
    nxt_sel_sync = sel_meta_ff;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_meta_ff <= 1'b0;
      sel_sync_ff <= 1'b0;
    end else begin
      sel_meta_ff <= nxt_sel_meta;
      sel_sync_ff <= nxt_sel_sync;
    end
  end

  // Read port; writes are dropped
  lmcp_byte_t rd_byte;
  logic       rd_take;
  lmcp_rsp_s  rsp_ff;
  lmcp_rsp_s  nxt_rsp;

  always_comb begin
    unique case (REQ.addr)
      `LMCP_OFS_PAGES:      rd_byte = PAGES_BYTE;
      `LMCP_OFS_DURATIONS:  rd_byte = DUR_BYTE;
      `LMCP_OFS_CHARACTER:  rd_byte = CHAR_BYTE;
      `LMCP_OFS_TEMP_MAX:   rd_byte = TEMP_MAX; // [R8]
      `LMCP_OFS_TEMP_MIN:   rd_byte = TEMP_MIN; // [R8]
      `LMCP_OFS_VOLT_FLOOR: rd_byte = VOLT_FLOOR; // [R9]
      `LMCP_OFS_DISABLE:    rd_byte = DIS_BYTE;
      `LMCP_OFS_CONTROLS_A: rd_byte = CTRL_A_BYTE;
      `LMCP_OFS_CONTROLS_B: rd_byte = CTRL_B_BYTE;
      `LMCP_OFS_FLAGS:      rd_byte = FLAG_BYTE;
      `LMCP_OFS_MONITORS_A: rd_byte = MON_A_BYTE;
      `LMCP_OFS_MONITORS_B: rd_byte = MON_B_BYTE;
      `LMCP_OFS_CMD_BLOCK:  rd_byte = CMD_BYTE;
      default:              rd_byte = 8'h00; // [R23]
    endcase
    rd_take       = REQ.valid && !REQ.write && sel_sync_ff; // [R22]
    nxt_rsp.valid = rd_take;
    nxt_rsp.rdata = rd_take ? rd_byte : rsp_ff.rdata;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign RSP = rsp_ff;

  // Address pointer advance with auto paging
  lmcp_ptr_s ptr_ff;
  lmcp_ptr_s nxt_ptr;
  logic      in_epl;
  logic      at_end;

  always_comb begin
    in_epl = (PTR_IN.page >= `LMCP_EPL_FIRST_PAGE) &&
             (PTR_IN.page <= EPL_LAST);
    at_end = PTR_IN.addr == `LMCP_PAGE_ADDR_LAST;
    nxt_ptr.advance = PTR_IN.advance;
    nxt_ptr.page    = ptr_ff.page;
    nxt_ptr.addr    = ptr_ff.addr;
    if (PTR_IN.advance) begin
      nxt_ptr.page = PTR_IN.page;
      nxt_ptr.addr = 8'(PTR_IN.addr + 8'h01);
      if (at_end) begin
        nxt_ptr.addr = `LMCP_PAGE_ADDR_FIRST; // [R20]
        if (AUTO_ON && in_epl) begin
          nxt_ptr.page = (PTR_IN.page == EPL_LAST) ?
            `LMCP_EPL_FIRST_PAGE : 8'(PTR_IN.page + 8'h01); // [R20]
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ptr_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  assign PTR_OUT = ptr_ff;

  // Lane shutoff combining
  logic [LANES-1:0] lane_dis_ff;
  logic [LANES-1:0] nxt_lane_dis;

  always_comb begin
    if (GLOBAL_SHUTOFF) begin
      nxt_lane_dis = {LANES{|LASER_LANE_OFF}}; // [R10]
    end else begin
      nxt_lane_dis = LASER_LANE_OFF; // [R10]
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lane_dis_ff <= '0;
    end else begin
      lane_dis_ff <= nxt_lane_dis;
    end
  end

  assign LASER_LANE_DISABLE  = lane_dis_ff;
  assign STATE_DURATION_CODE = STATE_DUR_CODE; // [R5]

  // Checks
  read_answer_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R22]
    REQ.valid && !REQ.write && sel_sync_ff |=> RSP.valid)
    else $error("read not answered next cycle");

  write_ignored_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R22]
    REQ.valid && REQ.write |=> !RSP.valid)
    else $error("write produced a read answer");

  deselect_quiet_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !sel_sync_ff |=> !RSP.valid) // [R4]
    else $error("answer while not selected");

  reserved_zero_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R23]
    rd_take && (REQ.addr == `LMCP_OFS_DUR_RSVD ||
    REQ.addr == `LMCP_OFS_FLAGS_RSVD || REQ.addr == `LMCP_OFS_CHR_RSVD_B)
    |=> RSP.rdata == 8'h00)
    else $error("reserved byte not zero");

  durations_byte_a: assert property (@(posedge CLK) disable iff (!RST_B)
    rd_take && REQ.addr == `LMCP_OFS_DURATIONS |=> // [R2]
    RSP.rdata == (WAIT_KNOWN ? {WAIT_EXPONENT, WAIT_MANTISSA} : 8'h00))
    else $error("durations byte wrong");

  cmd_byte_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R18]
    rd_take && REQ.addr == `LMCP_OFS_CMD_BLOCK |=>
    RSP.rdata[7:6] == CMD_INSTANCES && RSP.rdata[3:0] == EPL_RANGE &&
    RSP.rdata[5] == BACKGROUND)
    else $error("command block byte wrong");

  rdata_hold_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R22]
    !rd_take |=> $stable(RSP.rdata))
    else $error("read data changed without a read");

  page_wrap_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R20]
    PTR_IN.advance && PTR_IN.addr == 8'hff |=>
    PTR_OUT.addr == 8'h80 && PTR_OUT.advance)
    else $error("pointer did not wrap to 128");

  page_step_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R20]
    PTR_IN.advance && PTR_IN.addr != 8'hff |=>
    PTR_OUT.addr == $past(PTR_IN.addr) + 8'h01 &&
    PTR_OUT.page == $past(PTR_IN.page))
    else $error("pointer step wrong");

  global_off_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R10]
    GLOBAL_SHUTOFF && (|LASER_LANE_OFF) |=> &LASER_LANE_DISABLE)
    else $error("global shutoff left a lane on");

  lane_off_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R10]
    !GLOBAL_SHUTOFF |=> LASER_LANE_DISABLE == $past(LASER_LANE_OFF))
    else $error("per lane shutoff wrong");

endmodule

`default_nettype wire

// file: verification/lmcp_host_model.sv
/*
 Host controller model: drives the select pin and byte requests.
 Assumes the capability region answers on RSP one cycle after a read.
*/
`default_nettype none

module lmcp_host_model
  import lmcp_pkg::*;
#(
  parameter int SETTLE_CYCLES = 4
) (
  input  wire logic      clk,
  output logic           sel_n,
  output lmcp_req_s      req,
  input  wire lmcp_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sel_n = 1'b1;
    req   = '0;
  end

  // Settle time shortened so the run stays short
  task automatic settle();
    repeat (SETTLE_CYCLES) @(posedge clk);
  endtask

  task automatic select(input logic on);
    if (on) begin
      @(posedge clk);
      sel_n <= 1'b0;
      settle();
    end else begin
      settle();
      @(posedge clk);
      sel_n <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask

  // Released request lines carry the inverse, not the last value
  task automatic access(input logic wr, input lmcp_byte_t a,
                        input lmcp_byte_t d, output logic ok,
                        output lmcp_byte_t q);
    @(posedge clk);
    req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(posedge clk);
    req <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    #1;
    ok = rsp.valid;
    q  = rsp.rdata;
  endtask
endmodule

`default_nettype wire

// file: verification/laser_module_capability_page_tb.sv
/*
 Testbench of the capability region: map, writes, pointer, lanes.
 Assumes the host model file and the design package are compiled first.
*/
`default_nettype none

module laser_module_capability_page_tb;
  import lmcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       rst_b;
  logic       sel_n;
  lmcp_req_s  req;
  lmcp_rsp_s  rsp;
  lmcp_ptr_s  ptr_in;
  lmcp_ptr_s  ptr_out;
  logic [7:0] lane_off;
  logic [7:0] lane_dis;
  logic [3:0] dur_code;
  int         bad_count;
  int         total_checks;
  int         cycles;
  logic       ok;
  lmcp_byte_t q;
  lmcp_byte_t a;
  logic [15:0] np;
  int unsigned seed;

  // Configuration under test
  localparam logic [1:0] P_BANK   = 2'h2;
  localparam logic       P_ONE    = 1'b1;
  localparam logic [3:0] P_DUR    = 4'hd;
  localparam logic [2:0] P_AUX    = 3'h5;
  localparam logic [7:0] P_TMAX   = 8'h46;
  localparam logic [7:0] P_TMIN   = 8'hfb;
  localparam logic [7:0] P_VOLT   = 8'ha5;
  localparam logic [5:0] P_MON    = 6'h2b;
  localparam logic [1:0] P_BIAS   = 2'h2;
  localparam logic [1:0] P_INST   = 2'h1;
  localparam logic [3:0] P_EPL    = 4'h5;
  localparam int         P_SETTLE = 4;

  lmcp_capability_page #(
    .LANE_BANK_RANGE(P_BANK), .VENDOR_PAGES(P_ONE), .DIAG_PAGE(P_ONE),
    .PAGE_05_PRESENT(P_ONE), .PAGE_03_PRESENT(P_ONE),
    .STATE_DUR_CODE(P_DUR), .COOLED(P_ONE), .AUX_SOURCE(P_AUX),
    .TEMP_MAX(P_TMAX), .TEMP_MIN(P_TMIN), .VOLT_FLOOR(P_VOLT),
    .FAST_SHUTOFF(P_ONE), .GLOBAL_SHUTOFF(P_ONE), .WAVE_CONTROL(P_ONE),
    .TUNABLE(P_ONE), .BROADCAST(P_ONE), .LOSS_FLAG(P_ONE),
    .MONITORS(P_MON), .BIAS_MULT(P_BIAS), .OPT_POWER_MON(P_ONE),
    .CMD_INSTANCES(P_INST), .BACKGROUND(P_ONE), .AUTO_PAGE(P_ONE),
    .EPL_RANGE(P_EPL)
  ) i_dut (
    .CLK(clk), .RST_B(rst_b), .MODULE_SELECT_LINE_N(sel_n),
    .REQ(req), .RSP(rsp), .PTR_IN(ptr_in), .PTR_OUT(ptr_out),
    .LASER_LANE_OFF(lane_off), .LASER_LANE_DISABLE(lane_dis),
    .STATE_DURATION_CODE(dur_code)
  );

  lmcp_host_model #(.SETTLE_CYCLES(P_SETTLE)) i_host (
    .clk(clk), .sel_n(sel_n), .req(req), .rsp(rsp)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic lmcp_byte_t exp_byte(input lmcp_byte_t ad);
    case (ad)
      8'h8e: return {1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h2};
      8'h8f: return {3'h6, 5'h19};
      8'h91: return {1'b1, 4'h0, 3'h5};
      8'h92: return 8'h46;
      8'h93: return 8'hfb;
      8'h96: return 8'ha5;
      8'h97: return {6'h00, 1'b1, 1'b1};
      8'h9b: return {1'b1, 1'b1, 4'h0, 1'b1, 1'b0};
      8'h9c: return {1'b1, 7'h00};
      8'h9d: return {6'h00, 1'b1, 1'b0};
      8'h9f: return {2'h0, 6'h2b};
      8'ha0: return {3'h0, 2'h2, 1'b0, 1'b1, 1'b0};
      8'ha3: return {2'h1, 1'b1, 1'b1, 4'h5};
      default: return 8'h00;
    endcase
  endfunction

  // Eight payload pages: A0h to A7h
  function automatic logic [15:0] exp_ptr(input lmcp_byte_t pg,
                                          input lmcp_byte_t ad);
    if (ad != 8'hff) return {pg, ad + 8'h01};
    if (pg >= 8'ha0 && pg <= 8'ha7)
      return {(pg == 8'ha7) ? 8'ha0 : pg + 8'h01, 8'h80};
    return {pg, 8'h80};
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    rst_b = 1'b0;
    ptr_in = '0;
    lane_off = '0;
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    seed = $urandom(75);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check("rsp_reset", rsp, '0);
    check("dur_code", dur_code, 4'hd);
    i_host.select(1'b1);
    for (int i = 'h8c; i < 'hae; i++) begin
      a = (i >= 'ha6) ? 8'(($urandom % 'h40) + 'hb0) : 8'(i);
      i_host.access(1'b0, a, 8'h00, ok, q);
      check("read_ok", ok, 1'b1);
      check("rdata", q, exp_byte(a));
      check("rdata", q, exp_byte(a));
      check("rdata", q, exp_byte(a));
    end
    $display("test map done");
    repeat (10) begin
      a = 8'(($urandom % 22) + 'h8e);
      i_host.access(1'b1, a, 8'($urandom), ok, q);
      check("write_refused", ok, 1'b0);
      i_host.access(1'b0, a, 8'h00, ok, q);
      check("after_write", q, exp_byte(a));
    end
    $display("test writes done");
    for (int i = 0; i < 24; i++) begin
      np = (i < 4) ? {8'ha7 - 8'(i * 7), 8'hff}
                   : {8'(($urandom % 16) + 'h9c), 8'(i[0] ? 'hff : $urandom)};
      @(posedge clk);
      ptr_in <= '{advance: 1'b1, page: np[15:8], addr: np[7:0]};
      @(posedge clk);
      ptr_in.advance <= 1'b0;
      #1;
      check("ptr_adv", ptr_out.advance, 1'b1);
      check("ptr", {ptr_out.page, ptr_out.addr},
            exp_ptr(np[15:8], np[7:0]));
    end
    $display("test pointer done");
    for (int i = 0; i < 16; i++) begin
      np[7:0] = (i < 9) ? 8'((1 << i) >> 1) : 8'($urandom);
      @(posedge clk);
      lane_off <= np[7:0];
      @(posedge clk);
      #1;
      check("lane_dis", lane_dis, (np[7:0] == 0) ? 8'h00 : 8'hff);
    end
    $display("test lanes done");
    i_host.select(1'b0);
    i_host.access(1'b0, 8'h8f, 8'h00, ok, q);
    check("deselected", ok, 1'b0);
    $display("test deselect done");
    complete_run();
  end
endmodule

`default_nettype wire
